// file: inc/period_timer_pkg.sv
// Package for the 8-bit period-match timer: register map, control fields,
// reset values and shared carrier types.
// Assumes a single 125 MHz clock and a plain strobe register port.
package period_timer_pkg;

  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned ADDR_W  = 4;
  localparam int unsigned DATA_W  = 8;

  // Register offsets on the plain register port
  localparam logic [3:0] OFS_TICK_COUNT   = 4'h0;
  localparam logic [3:0] OFS_PERIOD_LIMIT = 4'h1;
  localparam logic [3:0] OFS_CONTROL      = 4'h2;
  localparam logic [3:0] OFS_IRQ_STATUS   = 4'h3;
  localparam logic [3:0] OFS_IRQ_MASK     = 4'h4;

  // Control register fields
  localparam int unsigned CTL_PRE_LSB  = 0;  // Prescaler select, 2 bits
  localparam int unsigned CTL_RUN_BIT  = 2;  // count_run_enable
  localparam int unsigned CTL_POST_LSB = 3;  // Postscaler ratio minus one, 4 bits
  localparam int unsigned CTL_TB_BIT   = 7;  // PWM time base select

  // Prescaler select codes
  localparam logic [1:0] PRE_DIV1  = 2'h0;
  localparam logic [1:0] PRE_DIV4  = 2'h1;
  localparam logic [1:0] PRE_DIV16 = 2'h2;

  // Reset values
  localparam logic [7:0] RST_TICK_COUNT   = 8'h00;
  localparam logic [7:0] RST_PERIOD_LIMIT = 8'hFF;
  localparam logic [7:0] RST_CONTROL      = 8'h00;
  localparam logic [7:0] RST_IRQ_MASK     = 8'h00;

  // Interrupt status bits
  localparam int unsigned IRQ_POST_BIT  = 0;  // Postscaled period match
  localparam int unsigned IRQ_MATCH_BIT = 1;  // Every raw period match

  // Register port request carrier
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

endpackage

// file: rtl/tick_prescaler.sv
// Prescaler for the period-match timer: makes a one-cycle tick enable at
// 1:1, 1:4 or 1:16 of the clock.
// Assumes the caller pulses clear on any write that restarts the scalers.
`timescale 1ns/1ps
module tick_prescaler
  import period_timer_pkg::*;
#(
  parameter int unsigned CNT_W = 4
)(
  input  wire logic       mclk,   // Clock
  input  wire logic       rst,    // Async reset, active high
  input  wire logic       run,    // Count enable
  input  wire logic       clear,  // Clear divider count
  input  wire logic [1:0] sel,    // Divide select
  output logic            tick    // One-cycle tick enable
);
  import period_timer_pkg::*;

  logic [CNT_W-1:0] div_count;
  logic [CNT_W-1:0] last_count;

  // Terminal value of the divider for the chosen ratio
  always_comb
  begin
    unique case (sel)
      PRE_DIV4:  last_count = CNT_W'(3);
      PRE_DIV16: last_count = CNT_W'(15);
      default:   last_count = '0;
    endcase
  end

  assign tick = run && (div_count == last_count);

  // Divider count; cleared on restart so the first tick is a full period
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      div_count <= '0;
    else if (clear)
      div_count <= '0;
    else if (tick)
      div_count <= '0;
    else if (run)
      div_count <= div_count + CNT_W'(1);
  end

  a_tick_spacing: assert property (@(posedge mclk) disable iff (rst)
    (sel == PRE_DIV4 && run && !clear && tick) ##1 (run && !clear && sel == PRE_DIV4)[*3]
      |-> !tick)
    else $error("prescaler tick came early at 1:4");
endmodule

// file: rtl/period_match_timer.sv
// Top of the 8-bit period-match timer with prescaler, postscaler,
// interrupt status and mask, and PWM time base output.
// Assumes a master that uses one-cycle read and write strobes, never both.
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module period_match_timer
  import period_timer_pkg::*;
(
  input  wire logic                        mclk,       // Clock, 125 MHz
  input  wire logic                        rst,        // Async reset, active high
  input  wire period_timer_pkg::reg_req_t  req,        // Register request
  input  wire logic                        ext_base,   // Other timer's match pulse
  output logic [7:0]                       rdata,      // Read data, cycle after strobe
  output logic                             irq,        // Level interrupt
  output logic                             match,      // One-cycle period match
  output logic                             pwm_base    // Selected PWM time base pulse
);
  import period_timer_pkg::*;

  logic [7:0] tick_count;
  logic [7:0] period_limit;
  logic [7:0] timer_control_reg;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [3:0] post_count;
  logic       tick;
  logic       count_run_enable;
  logic       scaler_clear;
  logic       post_event;
  logic       wr_count;
  logic       wr_period;
  logic       wr_ctl;
  logic       rd_status;
  logic [3:0] post_last;

  function automatic logic hit(input logic [3:0] ofs, input reg_req_t r);
    hit = (r.addr == ofs);
  endfunction

  assign wr_count  = req.wr && hit(OFS_TICK_COUNT, req);
  assign wr_period = req.wr && hit(OFS_PERIOD_LIMIT, req);
  assign wr_ctl    = req.wr && hit(OFS_CONTROL, req);
  assign rd_status = req.rd && hit(OFS_IRQ_STATUS, req);

  assign count_run_enable = timer_control_reg[CTL_RUN_BIT];
  assign post_last        = timer_control_reg[CTL_POST_LSB +: 4];
  // Restart both scalers on a count or control write
  assign scaler_clear     = wr_count || wr_ctl;

  tick_prescaler #(
    .CNT_W (4)
  ) u_pre (
    .mclk  (mclk),
    .rst   (rst),
    .run   (count_run_enable),
    .clear (scaler_clear),
    .sel   (timer_control_reg[CTL_PRE_LSB +: 2]),
    .tick  (tick)
  );

  // Match is the tick on which the count equals the period, with no scaler restart in that cycle
  assign match = tick && (tick_count == period_limit) && !scaler_clear;
  assign post_event = match && (post_count == post_last);

  // Running count: software write wins, control write leaves it alone
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      tick_count <= RST_TICK_COUNT;
    else if (wr_count)
      tick_count <= req.wdata;
    else if (match)
      tick_count <= 8'h00;
    else if (tick && !wr_ctl)
      tick_count <= tick_count + 8'h01;
  end

  // Period and control registers
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      period_limit      <= RST_PERIOD_LIMIT;
      timer_control_reg <= RST_CONTROL;
    end
    else
    begin
      if (wr_period)
        period_limit <= req.wdata;
      if (wr_ctl)
        timer_control_reg <= req.wdata;
    end
  end

  // Postscaler match counter
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      post_count <= 4'h0;
    else if (scaler_clear)
      post_count <= 4'h0;
    else if (post_event)
      post_count <= 4'h0;
    else if (match)
      post_count <= post_count + 4'h1;
  end

  // Sticky status: a new event beats the clear-on-read in the same cycle
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      irq_status <= 2'h0;
    else
    begin
      irq_status[IRQ_POST_BIT]  <= post_event ||
                                   (irq_status[IRQ_POST_BIT] && !rd_status);
      irq_status[IRQ_MATCH_BIT] <= match ||
                                   (irq_status[IRQ_MATCH_BIT] && !rd_status);
    end
  end

  // Mask register
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      irq_mask <= RST_IRQ_MASK[1:0];
    else if (req.wr && hit(OFS_IRQ_MASK, req))
      irq_mask <= req.wdata[1:0];
  end

  assign irq = |(irq_status & irq_mask);

  // Time base mux for PWM channels: this timer or the other one
  assign pwm_base = timer_control_reg[CTL_TB_BIT] ? ext_base : match;

  // Read data register; unmapped offsets read as zero
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      rdata <= 8'h00;
    else if (req.rd)
    begin
      unique case (req.addr)
        OFS_TICK_COUNT:   rdata <= tick_count;
        OFS_PERIOD_LIMIT: rdata <= period_limit;
        OFS_CONTROL:      rdata <= timer_control_reg;
        OFS_IRQ_STATUS:   rdata <= {6'h00, irq_status};
        OFS_IRQ_MASK:     rdata <= {6'h00, irq_mask};
        default:          rdata <= 8'h00;
      endcase
    end
    else
      rdata <= 8'h00;
  end

  // Core count, scaler and read-back checks
  a_match_wraps: assert property (@(posedge mclk) disable iff (rst)
    (match && !req.wr) |=> (tick_count == 8'h00))
    else $error("count did not wrap after period match");

  a_ctl_keeps_count: assert property (@(posedge mclk) disable iff (rst)
    (wr_ctl && !wr_count) |=> (tick_count == $past(tick_count)))
    else $error("control write changed the count");

  a_count_wr_clr: assert property (@(posedge mclk) disable iff (rst)
    wr_count |=> (post_count == 4'h0))
    else $error("count write left postscaler running");

  a_ctl_wr_clr: assert property (@(posedge mclk) disable iff (rst)
    wr_ctl |=> (post_count == 4'h0))
    else $error("control write left postscaler running");

  a_stop_holds: assert property (@(posedge mclk) disable iff (rst)
    (!count_run_enable && !wr_count) |=> (tick_count == $past(tick_count)))
    else $error("count moved while stopped");

  a_post_flag: assert property (@(posedge mclk) disable iff (rst)
    post_event |=> irq_status[IRQ_POST_BIT])
    else $error("postscaled match did not set the flag");

  a_match_equal: assert property (@(posedge mclk) disable iff (rst)
    match |-> (tick_count == period_limit))
    else $error("match without equal count");

  a_period_write: assert property (@(posedge mclk) disable iff (rst)
    wr_period |=> (period_limit == $past(req.wdata)))
    else $error("period write lost");

  a_irq_level: assert property (@(posedge mclk) disable iff (rst)
    (irq_status[IRQ_POST_BIT] && irq_mask[IRQ_POST_BIT]) |-> irq)
    else $error("unmasked status without interrupt");

  a_read_back: assert property (@(posedge mclk) disable iff (rst)
    (req.rd && req.addr == OFS_CONTROL && !req.wr) |=>
      (rdata == $past(timer_control_reg)))
    else $error("control read-back wrong");

  // Assertion helpers: cycles since the last tick and since the last match.
  // Both restart with the scalers and rest at zero while the timer is stopped.
  logic [4:0]  tick_gap;
  logic [4:0]  gap_limit;
  logic [12:0] stall_cycles;

  // Tick spacing minus one for each prescaler code; code 3 runs at 1:1
  always_comb
  begin
    unique case (timer_control_reg[CTL_PRE_LSB +: 2])
      PRE_DIV4:  gap_limit = 5'h03;
      PRE_DIV16: gap_limit = 5'h0F;
      default:   gap_limit = 5'h00;
    endcase
  end

  // Tick gap counter, kept apart from the divider so the check is independent
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      tick_gap <= 5'h00;
    else if (scaler_clear || tick || !count_run_enable)
      tick_gap <= 5'h00;
    else
      tick_gap <= tick_gap + 5'h01;
  end

  // Match stall counter; 256 ticks of 16 cycles is the longest legal wait
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      stall_cycles <= 13'h0000;
    else if (scaler_clear || match || !count_run_enable)
      stall_cycles <= 13'h0000;
    else
      stall_cycles <= stall_cycles + 13'h0001;
  end

  // Ticks come exactly at the selected ratio and nowhere else
  a_tick_ratio: assert property (@(posedge mclk) disable iff (rst)
    (count_run_enable && !scaler_clear) |-> (tick == (tick_gap == gap_limit)))
    else $error("prescaler tick off its ratio");

  // A running timer can never starve the match output
  a_match_bound: assert property (@(posedge mclk) disable iff (rst)
    stall_cycles <= 13'h0FFF)
    else $error("running timer went too long without a match");

  // Count register takes the written byte
  a_count_write: assert property (@(posedge mclk) disable iff (rst)
    wr_count |=> (tick_count == $past(req.wdata)))
    else $error("count write lost");

  // Control register takes the written byte
  a_ctl_write: assert property (@(posedge mclk) disable iff (rst)
    wr_ctl |=> (timer_control_reg == $past(req.wdata)))
    else $error("control write lost");

  // Mask register takes the low bits of the written byte
  a_mask_write: assert property (@(posedge mclk) disable iff (rst)
    (req.wr && hit(OFS_IRQ_MASK, req)) |=> (irq_mask == $past(req.wdata[1:0])))
    else $error("mask write lost");

  // Period only changes on its own write
  a_period_hold: assert property (@(posedge mclk) disable iff (rst)
    !wr_period |=> $stable(period_limit))
    else $error("period changed without a write");

  // Control only changes on its own write
  a_ctl_hold: assert property (@(posedge mclk) disable iff (rst)
    !wr_ctl |=> $stable(timer_control_reg))
    else $error("control changed without a write");

  // A stopped timer never matches
  a_stop_no_match: assert property (@(posedge mclk) disable iff (rst)
    !count_run_enable |-> !match)
    else $error("match while stopped");

  // A restart swallows a coinciding match
  a_clear_no_match: assert property (@(posedge mclk) disable iff (rst)
    scaler_clear |-> !match)
    else $error("match on a scaler restart");

  // Each tick short of the period steps the count by one, wrapping at 8 bits
  a_count_step: assert property (@(posedge mclk) disable iff (rst)
    (tick && !match && !req.wr) |=>
      (tick_count == $past(tick_count) + 8'h01))
    else $error("count did not step on a tick");

  // Every raw match leaves its sticky flag
  a_raw_flag: assert property (@(posedge mclk) disable iff (rst)
    match |=> irq_status[IRQ_MATCH_BIT])
    else $error("raw match did not set the flag");

  // A status read with no new event empties the status
  a_rd_clears: assert property (@(posedge mclk) disable iff (rst)
    (rd_status && !match) |=> (irq_status == 2'h0))
    else $error("status read did not clear");

  // Status read returns the flags as they stood before the clear
  a_status_read: assert property (@(posedge mclk) disable iff (rst)
    rd_status |=> (rdata == {6'h00, $past(irq_status)}))
    else $error("status read-back wrong");

  // Read data is zero outside the cycle after a read strobe
  a_rdata_idle: assert property (@(posedge mclk) disable iff (rst)
    !req.rd |=> (rdata == 8'h00))
    else $error("read data not idle");

  // Postscaler count never passes the selected ratio
  a_post_bound: assert property (@(posedge mclk) disable iff (rst)
    post_count <= post_last)
    else $error("postscaler passed its ratio");

  // Postscaler restarts after raising its event
  a_post_restart: assert property (@(posedge mclk) disable iff (rst)
    post_event |=> (post_count == 4'h0))
    else $error("postscaler did not restart");

  // Each match short of the ratio advances the postscaler
  a_post_step: assert property (@(posedge mclk) disable iff (rst)
    (match && !post_event) |=>
      (post_count == $past(post_count) + 4'h1))
    else $error("postscaler did not count a match");

  // Own match drives the PWM base when selected
  a_pwm_own: assert property (@(posedge mclk) disable iff (rst)
    !timer_control_reg[CTL_TB_BIT] |-> (pwm_base == match))
    else $error("PWM base not following own match");

  // Other timer's pulse drives the PWM base when selected
  a_pwm_ext: assert property (@(posedge mclk) disable iff (rst)
    timer_control_reg[CTL_TB_BIT] |-> (pwm_base == ext_base))
    else $error("PWM base not following other timer");

  // A fully masked status keeps the interrupt low
  a_irq_masked: assert property (@(posedge mclk) disable iff (rst)
    (irq_mask == 2'h0) |-> !irq)
    else $error("interrupt high with all sources masked");
endmodule

// file: verif/period_match_timer_test.sv
// Self-checking bench for the period-match timer: registers, scaler timing,
// interrupt status and mask, PWM base selection and mid-run reset.
// Assumes period_timer_pkg is compiled first and one 125 MHz clock.
`timescale 1ns/1ps
module period_match_timer_test;
  import period_timer_pkg::*;
  logic       mclk;
  logic       rst;
  reg_req_t   req;
  logic       ext_base;
  logic [7:0] rdata;
  logic       irq;
  logic       match;
  logic       pwm_base;
  logic [7:0] got;
  int         miscompares;
  int         checks_done;
  int         n;
  int         t;
  // Reset table; offsets 5 and F are unmapped and read zero
  logic [3:0] ofs [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hF};
  logic [7:0] rv  [7] = '{RST_TICK_COUNT, RST_PERIOD_LIMIT, RST_CONTROL, 8'h00,
                          RST_IRQ_MASK, 8'h00, 8'h00};
  logic [1:0] pre [4] = '{PRE_DIV1, PRE_DIV4, PRE_DIV16, 2'h3};
  int         div [4] = '{1, 4, 16, 1};
  logic [3:0] post [3] = '{4'h0, 4'h2, 4'hF};

  period_match_timer dut (
    .mclk     (mclk),
    .rst      (rst),
    .req      (req),
    .ext_base (ext_base),
    .rdata    (rdata),
    .irq      (irq),
    .match    (match),
    .pwm_base (pwm_base)
  );

  // Clock at 8 ns period
  initial mclk = 1'b0;
  always #4 mclk = ~mclk;

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error at %0t: value %h, expected %h", $time, g, e);
    end
  endtask

  task automatic chk_bit(input logic g, input logic e);
    checks_done++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error at %0t: flag %b, expected %b", $time, g, e);
    end
  endtask

  // Strobe high for one cycle, then a cycle gap so no signal is set twice
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk);
    req <= '{a, d, 1'b0, 1'b0};
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk);
    req <= '{a, 8'h00, 1'b0, 1'b0};
    #1 d = rdata;
  endtask

  // Bounded wait for the next match pulse; returns cycles waited
  task automatic wait_match(output int c);
    c = 0;
    do
    begin
      @(posedge mclk);
      #1 c++;
      if (c > 2000)
      begin
        miscompares++;
        results();
      end
    end while (match !== 1'b1);
  endtask

  task automatic check_reset();
    foreach (ofs[i])
    begin
      rd(ofs[i], got);
      chk(got, rv[i]);
    end
    $display("Test reset values done");
  endtask

  task automatic results();
    $display("Checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    rst = 1'b1;
    req = '0;
    ext_base = 1'b0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    check_reset();
    // Every register reads back what was written; run stays off
    wr(OFS_PERIOD_LIMIT, 8'hA5);
    wr(OFS_TICK_COUNT, 8'h3C);
    wr(OFS_CONTROL, 8'h5A);
    wr(OFS_IRQ_MASK, 8'h03);
    rd(OFS_PERIOD_LIMIT, got);
    chk(got, 8'hA5);
    rd(OFS_TICK_COUNT, got);
    chk(got, 8'h3C);
    rd(OFS_CONTROL, got);
    chk(got, 8'h5A);
    rd(OFS_IRQ_MASK, got);
    chk(got, 8'h03);
    // Stopped timer holds its count, control write keeps it too
    wr(OFS_TICK_COUNT, 8'h05);
    wr(OFS_CONTROL, 8'h02);
    repeat (40) @(posedge mclk);
    rd(OFS_TICK_COUNT, got);
    chk(got, 8'h05);
    $display("Test registers done");
    // Match spacing is prescale ratio times period plus one
    wr(OFS_PERIOD_LIMIT, 8'h03);
    foreach (pre[i])
    begin
      wr(OFS_CONTROL, {6'h01, pre[i]});
      wait_match(t);
      wait_match(t);
      chk(t[7:0], 8'(div[i] * 4));
      chk_bit(pwm_base, 1'b1);
    end
    $display("Test prescaler done");
    // Postscaler: matches counted until the masked flag raises irq
    wr(OFS_IRQ_MASK, 8'h01);
    wr(OFS_PERIOD_LIMIT, 8'h01);
    foreach (post[i])
    begin
      wr(OFS_CONTROL, 8'h00);
      wr(OFS_TICK_COUNT, 8'h00);
      rd(OFS_IRQ_STATUS, got);
      wr(OFS_CONTROL, {1'b0, post[i], 3'h4});
      n = 0;
      for (t = 0; t < 200 && irq !== 1'b1; t++)
      begin
        @(posedge mclk);
        #1 n += (match === 1'b1);
      end
      if (irq !== 1'b1)
      begin
        miscompares++;
        results();
      end
      chk(8'(n), 8'(post[i] + 1));
      wr(OFS_CONTROL, 8'h00);
      rd(OFS_IRQ_STATUS, got);
      chk(got, 8'h03);
      chk_bit(irq, 1'b0);
    end
    // Masked out: raw matches set status but irq stays low
    wr(OFS_IRQ_MASK, 8'h00);
    wr(OFS_CONTROL, 8'h04);
    wait_match(t);
    repeat (2) @(posedge mclk);
    #1 chk_bit(irq, 1'b0);
    rd(OFS_IRQ_STATUS, got);
    chk(got & 8'h02, 8'h02);
    $display("Test postscaler done");
    // Control write on a slow running timer leaves the count alone
    // Stop first, so the count cannot move between its write and the start
    wr(OFS_CONTROL, 8'h00);
    wr(OFS_PERIOD_LIMIT, 8'hC8);
    wr(OFS_TICK_COUNT, 8'h09);
    wr(OFS_CONTROL, {6'h01, PRE_DIV16});
    rd(OFS_TICK_COUNT, got);
    chk(got, 8'h09);
    wr(OFS_CONTROL, {6'h05, PRE_DIV16});
    rd(OFS_TICK_COUNT, got);
    chk(got, 8'h09);
    // Writes every 8 cycles restart a 1:16 prescaler, so no match appears
    wr(OFS_PERIOD_LIMIT, 8'h00);
    wr(OFS_TICK_COUNT, 8'h00);
    n = 0;
    for (int k = 0; k < 12; k++)
    begin
      if (k % 2)
        wr(OFS_TICK_COUNT, 8'h00);
      else
        wr(OFS_CONTROL, {6'h01, PRE_DIV16});
      repeat (6)
      begin
        @(posedge mclk);
        #1 n += (match === 1'b1);
      end
    end
    chk(8'(n), 8'h00);
    // First 1:16 tick lands 16 cycles after the last restart
    wait_match(t);
    chk(t[7:0], 8'h09);
    $display("Test scaler clear done");
    // Alternate time base follows the other timer's pulse
    wr(OFS_CONTROL, 8'h80);
    @(posedge mclk);
    ext_base <= 1'b1;
    #1 chk_bit(pwm_base, 1'b1);
    @(posedge mclk);
    ext_base <= 1'b0;
    #1 chk_bit(pwm_base, 1'b0);
    $display("Test time base done");
    // Second reset in mid-run returns every register to its reset value
    wr(OFS_CONTROL, 8'h04);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    check_reset();
    results();
  end
endmodule
